// File: core/srw_pkg.sv
// package for the supply supervisor reset block
// assumes a 20 MHz system clock; counts derive from times below
package srw_pkg;
   localparam int unsigned CLK_HZ        = 20000000;
   // reset hold delay, milliseconds
   localparam int unsigned HOLD_MS       = 200;
   localparam longint unsigned HOLD_CYC  = (longint'(HOLD_MS) * CLK_HZ) / 1000;
   // kick timeout period, milliseconds (1.6 s)
   localparam int unsigned KICK_MS       = 1600;
   localparam longint unsigned KICK_CYC  = (longint'(KICK_MS) * CLK_HZ) / 1000;
   // manual reset noise filter, microseconds
   localparam int unsigned MRF_US        = 20;
   localparam int unsigned MRF_CYC       = (MRF_US * (CLK_HZ / 1000000));
   // output variant selection
   typedef enum logic [1:0] {
      SRW_OD_EXT = 2'h0,
      SRW_OD_INT = 2'h1,
      SRW_PP_LOW = 2'h2,
      SRW_PP_HIGH = 2'h3
   } srw_variant_t;
   typedef enum logic [1:0] {
      SRW_ASSERTED,
      SRW_HOLDING,
      SRW_RELEASED
   } srw_state_t;
endpackage

// File: core/srw_top.sv
// supply supervisor reset logic: causes, hold delay, kick timer, pin drive
// assumes supply flag from an analog comparator with hysteresis already applied
`timescale 1ns/1ps
module srw_top
   import srw_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = 32'(HOLD_CYC),
   parameter int unsigned KICK_CYCLES = 32'(KICK_CYC),
   parameter int unsigned MRF_CYCLES  = MRF_CYC,
   parameter logic [1:0]  VARIANT     = SRW_PP_LOW
) (
   input  wire logic CLK_I,
   input  wire logic RST_I,
   input  wire logic SUPPLY_OK_I,
   input  wire logic MANUAL_RESET_INPUT_N_I,
   input  wire logic WATCHDOG_KICK_INPUT_I,
   output logic      RESET_N_O,
   output logic      RESET_N_OE_N_O,
   output logic      PULLUP_EN_O,
   output logic      RESET_O,
   output logic      KICK_ARMED_O
);
   localparam int CW    = 32;
   localparam int NSYNC = 3;
   // idle level per synchroniser so no false cause or edge follows reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = 3'h6;

   // synchroniser taps: bit 0 supply, bit 1 manual, bit 2 kick
   wire  [NSYNC-1:0] sync_in;
   wire  [NSYNC-1:0] sync_lvl;

   // power-up, filter and kick timer state
   logic             por_r;
   logic             kick_old_r;
   logic [CW-1:0]    mrf_cnt_r;
   logic [CW-1:0]    mrf_cnt_nxt;
   logic             mr_filt_r;
   logic             mr_filt_nxt;
   logic             armed_r;
   logic             armed_nxt;
   logic [CW-1:0]    kick_cnt_r;
   logic [CW-1:0]    kick_cnt_nxt;
   logic             kick_to_r;

   // sequencer state and pin drive
   srw_state_t       state_r;
   srw_state_t       state_nxt;
   logic [CW-1:0]    hold_cnt_r;
   logic [CW-1:0]    hold_cnt_nxt;
   logic             in_reset_nxt;
   logic             oe_n_nxt;
   logic             pu_nxt;

   // pin idle levels match SYNC_IDLE bit for bit
   assign sync_in = {WATCHDOG_KICK_INPUT_I, MANUAL_RESET_INPUT_N_I, SUPPLY_OK_I};

   // two flops per input; stage 0 is only read by stage 1
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         logic [1:0] chain_r;
         always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
               chain_r <= {2{SYNC_IDLE[gi]}};
            end else begin
               chain_r <= {chain_r[0], sync_in[gi]};
            end
         end
         assign sync_lvl[gi] = chain_r[1];
      end
   endgenerate

   wire supply_ok = sync_lvl[0];
   wire mr_now_n  = sync_lvl[1];
   wire kick_now  = sync_lvl[2];

   // power-up cause for one cycle after reset, before any input is seen
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         por_r <= 1'b1;
      end else begin
         por_r <= 1'b0;
      end
   end

   // third flop on the kick line only, for edge detection
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         kick_old_r <= SYNC_IDLE[2];
      end else begin
         kick_old_r <= kick_now;
      end
   end

   wire kick_rise = kick_now & ~kick_old_r;
   wire kick_fall = ~kick_now & kick_old_r;
   wire kick_edge = kick_rise | kick_fall;

   // manual filter: a new level must persist MRF_CYCLES before it is taken
   wire mr_differs = (mr_now_n != mr_filt_r);
   wire mrf_done   = (mrf_cnt_r >= MRF_CYCLES - 1);

   // counter restarts whenever the raw level agrees again
   always_comb begin
      mrf_cnt_nxt = mrf_cnt_r + 1'b1;
      mr_filt_nxt = mr_filt_r;
      if (!mr_differs) begin
         mrf_cnt_nxt = '0;
      end else if (mrf_done) begin
         mrf_cnt_nxt = '0;
         mr_filt_nxt = mr_now_n;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mrf_cnt_r <= '0;
      end else begin
         mrf_cnt_r <= mrf_cnt_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mr_filt_r <= 1'b1;
      end else begin
         mr_filt_r <= mr_filt_nxt;
      end
   end

   // kick timer; expiry disarms, so a fresh falling edge is needed to re-arm
   wire kick_late   = (kick_cnt_r >= KICK_CYCLES - 1);
   wire kick_expire = armed_r & ~kick_edge & kick_late;

   always_comb begin
      armed_nxt    = armed_r;
      kick_cnt_nxt = kick_cnt_r + 1'b1;
      if (!armed_r) begin
         armed_nxt    = kick_fall;
         kick_cnt_nxt = '0;
      end else if (kick_edge) begin
         kick_cnt_nxt = '0;
      end else if (kick_expire) begin
         armed_nxt    = 1'b0;
         kick_cnt_nxt = '0;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= armed_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         kick_cnt_r <= '0;
      end else begin
         kick_cnt_r <= kick_cnt_nxt;
      end
   end

   // one-cycle timeout pulse; the sequencer stretches it into a full reset
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         kick_to_r <= 1'b0;
      end else begin
         kick_to_r <= kick_expire;
      end
   end

   // one named wire per cause keeps the combination readable
   wire cause_supply = ~supply_ok;
   wire cause_manual = ~mr_filt_r;
   wire cause_kick   = kick_to_r;
   wire cause_power  = por_r;
   wire cause        = cause_supply | cause_manual | cause_kick | cause_power;
   wire hold_done    = (hold_cnt_r >= HOLD_CYCLES - 1);

   // hold counter only runs in HOLDING; any cause restarts the delay
   always_comb begin
      state_nxt    = state_r;
      hold_cnt_nxt = hold_cnt_r;
      case (state_r)
         SRW_ASSERTED: begin
            hold_cnt_nxt = '0;
            if (!cause) begin
               state_nxt = SRW_HOLDING;
            end
         end
         SRW_HOLDING: begin
            if (cause) begin
               state_nxt    = SRW_ASSERTED;
               hold_cnt_nxt = '0;
            end else if (hold_done) begin
               state_nxt = SRW_RELEASED;
            end else begin
               hold_cnt_nxt = hold_cnt_r + 1'b1;
            end
         end
         SRW_RELEASED: begin
            if (cause) begin
               state_nxt = SRW_ASSERTED;
            end
         end
         // unreachable codes fall back to asserted
         default: begin
            state_nxt    = SRW_ASSERTED;
            hold_cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= SRW_ASSERTED;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         hold_cnt_r <= '0;
      end else begin
         hold_cnt_r <= hold_cnt_nxt;
      end
   end

   // outputs follow the next state, so both polarities switch on one edge
   assign in_reset_nxt = (state_nxt != SRW_RELEASED);
   wire od_ext = (VARIANT == SRW_OD_EXT);
   wire od_int = (VARIANT == SRW_OD_INT);
   // push-pull variants always drive; open-drain floats when released
   assign oe_n_nxt = (od_ext | od_int) & ~in_reset_nxt;
   // internal pull-up disconnected while driving low to save current
   assign pu_nxt   = od_int & ~in_reset_nxt;

   // registered outputs: no decode glitch reaches a pin
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RESET_N_O <= 1'b0;
      end else begin
         RESET_N_O <= ~in_reset_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RESET_N_OE_N_O <= 1'b0;
      end else begin
         RESET_N_OE_N_O <= oe_n_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PULLUP_EN_O <= 1'b0;
      end else begin
         PULLUP_EN_O <= pu_nxt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RESET_O <= 1'b1;
      end else begin
         RESET_O <= in_reset_nxt;
      end
   end

   // status only; lags the internal arm by a cycle
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         KICK_ARMED_O <= 1'b0;
      end else begin
         KICK_ARMED_O <= armed_r;
      end
   end
endmodule

// File: tb/srw_props.sv
// checker for the supervisor reset block ports
// bound into every srw_top; variant handed on
`timescale 1ns/1ps
module srw_props #(
   parameter logic [1:0] VARIANT = 2'h2
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic SUPPLY_OK_I,
   input wire logic MANUAL_RESET_INPUT_N_I,
   input wire logic WATCHDOG_KICK_INPUT_I,
   input wire logic RESET_N_O,
   input wire logic RESET_N_OE_N_O,
   input wire logic PULLUP_EN_O,
   input wire logic RESET_O,
   input wire logic KICK_ARMED_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   pol_pair_a: assert property (RESET_O == !RESET_N_O)
      else $error("reset pair not opposite");
   sup_trip_a: assert property ($fell(SUPPLY_OK_I) |-> ##[1:4] !RESET_N_O)
      else $error("supply drop missed");
   hold_full_a: assert property ($rose(RESET_N_O) |->
      $past(SUPPLY_OK_I, 16) && $past(MANUAL_RESET_INPUT_N_I, 16))
      else $error("release before hold delay");
   od_float_a: assert property (RESET_N_OE_N_O == (VARIANT < 2'h2 && RESET_N_O))
      else $error("pin enable wrong");
   pull_up_a: assert property (PULLUP_EN_O == (VARIANT == 2'h1 && RESET_N_O))
      else $error("pull-up wrong");
   manual_force_a: assert property (!MANUAL_RESET_INPUT_N_I [*8] |-> ##[0:2] !RESET_N_O)
      else $error("manual reset missed");
   arm_fall_a: assert property ($rose(KICK_ARMED_O) |-> !$past(WATCHDOG_KICK_INPUT_I, 3))
      else $error("armed without falling edge");
   kick_fire_a: assert property ($fell(KICK_ARMED_O) |-> ##[0:2] !RESET_N_O)
      else $error("timeout without reset");
endmodule
bind srw_top srw_props #(.VARIANT(VARIANT)) i_props (.*);

// File: tb/srw_host.sv
// host model: toggles the kick line every gap+1 cycles
// only while enabled and its reset pin is high
`timescale 1ns/1ps
module srw_host (
   input  wire logic       clk_i,
   input  wire logic       rst_pin_i,
   input  wire logic       run_i,
   input  wire logic [5:0] gap_i,
   output logic            kick_o
);
   logic [5:0] cnt_r = 6'h0;
   initial kick_o = 1'b1;
   always @(negedge clk_i) begin
      cnt_r <= (cnt_r >= gap_i) ? 6'h0 : cnt_r + 6'h1;
      if (run_i && rst_pin_i && cnt_r == 6'h0) kick_o <= !kick_o;
   end
endmodule

// File: tb/srw_tb_top.sv
// bench: open-drain internal, open-drain external and push-pull variants side by side
// needs srw_pkg, srw_top, srw_host and srw_props
`timescale 1ns/1ps
module srw_tb_top;
   import srw_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sup = 1'b0, mr_n = 1'b1, run = 1'b0;
   logic [5:0] gap = 6'h10;
   logic rn, oe_n, pu, ro, arm, kick, pin;
   logic rn_e, oe_n_e, pu_e, ro_e, rn_p, oe_n_p, pu_p, ro_p;
   logic q[$];
   int errors = 0, checks = 0;
   always #25 clk = !clk;
   assign pin = oe_n ? pu : rn;
   srw_top #(.HOLD_CYCLES(20), .KICK_CYCLES(50), .MRF_CYCLES(4), .VARIANT(SRW_OD_INT)) i_dut (
      .CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(sup), .MANUAL_RESET_INPUT_N_I(mr_n),
      .WATCHDOG_KICK_INPUT_I(kick), .RESET_N_O(rn), .RESET_N_OE_N_O(oe_n),
      .PULLUP_EN_O(pu), .RESET_O(ro), .KICK_ARMED_O(arm));
   srw_host i_host (.clk_i(clk), .rst_pin_i(pin), .run_i(run), .gap_i(gap), .kick_o(kick));
   srw_top #(.HOLD_CYCLES(20), .KICK_CYCLES(50), .MRF_CYCLES(4),
      .VARIANT(SRW_OD_EXT)) i_dut_ext (
      .CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(sup), .MANUAL_RESET_INPUT_N_I(mr_n),
      .WATCHDOG_KICK_INPUT_I(kick), .RESET_N_O(rn_e), .RESET_N_OE_N_O(oe_n_e),
      .PULLUP_EN_O(pu_e), .RESET_O(ro_e), .KICK_ARMED_O());
   srw_top #(.HOLD_CYCLES(20), .KICK_CYCLES(50), .MRF_CYCLES(4),
      .VARIANT(SRW_PP_LOW)) i_dut_pp (
      .CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(sup), .MANUAL_RESET_INPUT_N_I(mr_n),
      .WATCHDOG_KICK_INPUT_I(kick), .RESET_N_O(rn_p), .RESET_N_OE_N_O(oe_n_p),
      .PULLUP_EN_O(pu_p), .RESET_O(ro_p), .KICK_ARMED_O());
   task automatic chk(input logic s, input logic e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wt(input logic v, output int n);
      n = 0;
      while (ro !== v) begin
         @(negedge clk);
         n++;
         if (n > 200) begin
            errors++;
            print_verdict();
         end
      end
   endtask
   // an output change with nothing queued is a spurious reset
   always @(ro) if (!rst) begin
      #1;
      if (q.size() == 0) chk(ro, !ro);
      else chk(ro, q.pop_front());
      chk(pin, !ro);
      chk(oe_n_e, !ro);
      chk(pu_e, 1'b0);
      chk(rn_e, !ro);
      chk(ro_e, ro);
      chk(oe_n_p, 1'b0);
      chk(pu_p, 1'b0);
      chk(rn_p, !ro);
      chk(ro_p, ro);
   end
   initial begin
      int n;
      void'($urandom(32'h5EFACE4B));
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk(ro, 1'b1);
      q = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      sup = 1'b1;
      wt(1'b0, n);
      chk(n >= 20, 1'b1);
      mr_n = 1'b0;
      repeat (3) @(negedge clk);
      mr_n = 1'b1;
      repeat (15) @(negedge clk);
      mr_n = 1'b0;
      wt(1'b1, n);
      chk(n <= 9, 1'b1);
      mr_n = 1'b1;
      wt(1'b0, n);
      repeat (60) @(negedge clk);
      gap = 6'($urandom_range(40, 8));
      run = 1'b1;
      repeat (400) @(negedge clk);
      chk(arm, 1'b1);
      run = 1'b0;
      wt(1'b1, n);
      chk(n <= 60, 1'b1);
      wt(1'b0, n);
      repeat (60) @(negedge clk);
      sup = 1'b0;
      wt(1'b1, n);
      chk(n <= 4, 1'b1);
      sup = 1'b1;
      wt(1'b0, n);
      chk(n >= 20, 1'b1);
      repeat (5) @(negedge clk);
      chk(q.size() == 0, 1'b1);
      print_verdict();
   end
endmodule
